// *** bcr_consts.svh ***
// Purpose: Offsets, field positions and reset values of the bridge header registers
// Assumes: Byte addresses of configuration dwords, 8-bit address space
// Notes:   Definitions only
`ifndef BCR_CONSTS_SVH
`define BCR_CONSTS_SVH

`define BCR_OFF_IO_UPPER    8'h30
`define BCR_OFF_CAP_PTR     8'h34
`define BCR_OFF_INT_CTRL    8'h3c
`define BCR_CAP_PTR_VALUE   8'hdc
`define BCR_INT_PIN_VALUE   8'h00
`define BCR_BIT_PERR_RESP   16
`define BCR_BIT_SERR_FWD    17
`define BCR_BIT_ISA_EN      18
`define BCR_UPPER_RESET     16'h0000
`define BCR_IO_GRAN_BITS    12
`define BCR_ISA_TOP         16'hffff
`define BCR_SYNC_IDLE       1'b1

`endif

// *** bcr_pkg.sv ***
// Purpose: Types shared by the bridge header register block
// Assumes: Nothing beyond the constants header
// Notes:   Whole block state is one packed struct
package bcr_pkg;

	typedef struct packed {
		logic [15:0] io_base_upper;
		logic [15:0] io_window_top_upper_half;
		logic        perr_resp;
		logic        serr_fwd;
		logic        isa_en;
		logic [31:0] rdata;
		logic        rvalid;
		logic        sync1;
		logic        sync2;
		logic        sync3;
		logic        serr_seen;
		logic        perr_out_n;
		logic        perr_oe_n;
		logic        dpr_set;
		logic        serr_out_n;
		logic        serr_oe_n;
		logic        fwd_down;
		logic        fwd_up;
	} bcr_state_s;

endpackage : bcr_pkg

// *** bcr_io_decode.sv ***
// Purpose: I/O window and ISA alias decode for one bus side
// Assumes: Upper and low base/limit bits supplied by the caller
// Notes:   Purely combinational; the caller registers the results
`timescale 1ns/10ps
`include "bcr_consts.svh"

module bcr_io_decode (
	input  wire logic [31:0] i_addr,
	input  wire logic [15:0] i_base_upper,
	input  wire logic [3:0]  i_base_low,
	input  wire logic [15:0] i_limit_upper,
	input  wire logic [3:0]  i_limit_low,
	output logic             o_in_window,
	output logic             o_isa_alias
);
	logic [31:0] base;
	logic [31:0] limit;

	// Window is 4 kB aligned; limit fills its unnamed low bits with ones
	assign base  = {i_base_upper, i_base_low, {`BCR_IO_GRAN_BITS{1'b0}}};
	assign limit = {i_limit_upper, i_limit_low, {`BCR_IO_GRAN_BITS{1'b1}}};
	assign o_in_window = (i_addr >= base) && (i_addr <= limit);

	// Last 768 bytes of a 1 kB block inside the first 64 kB
	assign o_isa_alias = (i_addr[31:16] == 16'h0000) && (i_addr[9:8] != 2'h0);

endmodule : bcr_io_decode

// *** bcr_regs.sv ***
// Summary of operation
// - Read/write I/O window top bits 31:16 in upper half of dword 0x30, reset zero.
// - I/O window compare uses 4 kB alignment and granularity.
// - Dword 0x34 bits 7:0 read fixed 0xdc, the first capability.
// - Dword 0x34 bits 31:8 read zero and ignore writes.
// - Interrupt pin field, bits 15:8 of dword 0x3c, reads zero.
// - Parity response clear: no parity pin, no reported bit, no address-parity error.
// - Parity response set: drive parity pin and conditionally set reported bit.
// - Secondary address parity reaches system error line only with parity response set.
// - Forward enable clear: secondary system error never drives primary line.
// - Forward and driver enable set: secondary system error drives primary line.
// - ISA clear: forward every primary I/O access inside the window downstream.
// - ISA set: ignore primary window accesses in top 768 bytes per 1 kB below 64 kB.
// - ISA set: forward those secondary alias accesses upstream.
// - Read/write I/O window bottom bits 31:16 in lower half of dword 0x30, reset zero.
//
// Purpose: Part of the bridge type 1 header plus error and I/O forwarding control
// Assumes: One configuration access per request cycle, byte enables active low
// Notes:   All outputs come from the state struct; reset is synchronous
`timescale 1ns/10ps
`include "bcr_consts.svh"

module bcr_regs (
	input  wire logic        i_mclk,
	input  wire logic        i_nrst,
	input  wire logic        i_cfg_wr,
	input  wire logic        i_cfg_rd,
	input  wire logic [7:0]  i_cfg_addr,
	input  wire logic [31:0] i_cfg_wdata,
	input  wire logic [3:0]  i_upstream_command_byte_enables_n,
	input  wire logic [3:0]  i_io_base_low,
	input  wire logic [3:0]  i_io_limit_low,
	input  wire logic        i_serr_driver_en,
	input  wire logic        i_dpr_condition,
	input  wire logic        i_sec_data_parity_err,
	input  wire logic        i_sec_addr_parity_err,
	input  wire logic        i_downstream_system_error_in_n,
	input  wire logic        i_pri_io_valid,
	input  wire logic [31:0] i_pri_io_addr,
	input  wire logic        i_sec_io_valid,
	input  wire logic [31:0] i_sec_io_addr,
	output logic [31:0]      o_cfg_rdata,
	output logic             o_cfg_rvalid,
	output logic             o_downstream_parity_error_out_n,
	output logic             o_downstream_parity_error_oe_n,
	output logic             o_data_parity_reported_set,
	output logic             o_upstream_system_error_out_n,
	output logic             o_upstream_system_error_oe_n,
	output logic             o_fwd_downstream,
	output logic             o_fwd_upstream,
	output logic             o_isa_en,
	output logic [15:0]      o_io_window_top_upper_half
);
	bcr_pkg::bcr_state_s st;
	bcr_pkg::bcr_state_s next_st;
	logic                pri_in;
	logic                pri_alias;
	logic                sec_in;
	logic                sec_alias;
	logic                be0;
	logic                be1;
	logic                be2;
	logic                be3;

	assign be0 = !i_upstream_command_byte_enables_n[0];
	assign be1 = !i_upstream_command_byte_enables_n[1];
	assign be2 = !i_upstream_command_byte_enables_n[2];
	assign be3 = !i_upstream_command_byte_enables_n[3];

	// Both directions use the same decoder module on the same window bits so the two can never disagree on the window
	bcr_io_decode u_pri_dec (
		.i_addr        (i_pri_io_addr),
		.i_base_upper  (st.io_base_upper),
		.i_base_low    (i_io_base_low),
		.i_limit_upper (st.io_window_top_upper_half),
		.i_limit_low   (i_io_limit_low),
		.o_in_window   (pri_in),
		.o_isa_alias   (pri_alias)
	);

	bcr_io_decode u_sec_dec (
		.i_addr        (i_sec_io_addr),
		.i_base_upper  (st.io_base_upper),
		.i_base_low    (i_io_base_low),
		.i_limit_upper (st.io_window_top_upper_half),
		.i_limit_low   (i_io_limit_low),
		.o_in_window   (sec_in),
		.o_isa_alias   (sec_alias)
	);

	// Next-state logic for registers, error signalling and forwarding decisions
	always_comb begin
		next_st = st;
		next_st.rvalid = 1'b0;
		// Register writes, per byte lane
		if (i_cfg_wr && i_cfg_addr == `BCR_OFF_IO_UPPER) begin
			if (be0) next_st.io_base_upper[7:0] = i_cfg_wdata[7:0];
			if (be1) next_st.io_base_upper[15:8] = i_cfg_wdata[15:8];
			if (be2) next_st.io_window_top_upper_half[7:0] = i_cfg_wdata[23:16];
			if (be3) next_st.io_window_top_upper_half[15:8] = i_cfg_wdata[31:24];
		end
		// Capability pointer dword has no writable bits at all
		if (i_cfg_wr && i_cfg_addr == `BCR_OFF_INT_CTRL && be2) begin
			next_st.perr_resp = i_cfg_wdata[`BCR_BIT_PERR_RESP];
			next_st.serr_fwd  = i_cfg_wdata[`BCR_BIT_SERR_FWD];
			next_st.isa_en    = i_cfg_wdata[`BCR_BIT_ISA_EN];
		end
		// Read data registered one cycle after the request
		if (i_cfg_rd) begin
			next_st.rvalid = 1'b1;
			case (i_cfg_addr)
				`BCR_OFF_IO_UPPER: begin
					next_st.rdata = {st.io_window_top_upper_half, st.io_base_upper};
				end
				`BCR_OFF_CAP_PTR: begin
					next_st.rdata = {24'h000000, `BCR_CAP_PTR_VALUE};
				end
				`BCR_OFF_INT_CTRL: begin
					next_st.rdata = {13'h0000, st.isa_en, st.serr_fwd, st.perr_resp,
						`BCR_INT_PIN_VALUE, 8'h00};
				end
				default: begin
					next_st.rdata = 32'h00000000;
				end
			endcase
		end
		// Three-stage pin synchroniser; a change counts once stages two and three agree
		next_st.sync1 = i_downstream_system_error_in_n;
		next_st.sync2 = st.sync1;
		next_st.sync3 = st.sync2;
		if (st.sync2 == st.sync3) next_st.serr_seen = !st.sync3;
		// Parity pin and reported bit only with parity response set
		next_st.perr_out_n = !(i_sec_data_parity_err && st.perr_resp);
		next_st.perr_oe_n  = !(i_sec_data_parity_err && st.perr_resp);
		next_st.dpr_set    = i_sec_data_parity_err && st.perr_resp && i_dpr_condition;
		// Open-drain system error, driven low while any enabled source is active
		next_st.serr_out_n = !((i_sec_addr_parity_err && st.perr_resp && i_serr_driver_en)
			|| (st.serr_seen && st.serr_fwd && i_serr_driver_en));
		next_st.serr_oe_n = next_st.serr_out_n;
		// Forwarding decisions; ISA filter only bites inside the window
		next_st.fwd_down  = i_pri_io_valid && pri_in && !(st.isa_en && pri_alias);
		next_st.fwd_up    = i_sec_io_valid && (!sec_in || (st.isa_en && sec_alias));
		// Synchronous reset; the capability value is a constant, never stored
		if (!i_nrst) begin
			next_st = '0;
			next_st.io_base_upper            = `BCR_UPPER_RESET;
			next_st.io_window_top_upper_half = `BCR_UPPER_RESET;
			next_st.sync1      = `BCR_SYNC_IDLE;
			next_st.sync2      = `BCR_SYNC_IDLE;
			next_st.sync3      = `BCR_SYNC_IDLE;
			next_st.perr_out_n = 1'b1;
			next_st.perr_oe_n  = 1'b1;
			next_st.serr_out_n = 1'b1;
			next_st.serr_oe_n  = 1'b1;
		end
	end

	// Single state register
	always_ff @(posedge i_mclk) begin
		st <= next_st;
	end

	// Outputs straight from flip-flops
	assign o_cfg_rdata                     = st.rdata;
	assign o_cfg_rvalid                    = st.rvalid;
	assign o_downstream_parity_error_out_n = st.perr_out_n;
	assign o_downstream_parity_error_oe_n  = st.perr_oe_n;
	assign o_data_parity_reported_set      = st.dpr_set;
	assign o_upstream_system_error_out_n   = st.serr_out_n;
	assign o_upstream_system_error_oe_n    = st.serr_oe_n;
	assign o_fwd_downstream                = st.fwd_down;
	assign o_fwd_upstream                  = st.fwd_up;
	assign o_isa_en                        = st.isa_en;
	assign o_io_window_top_upper_half      = st.io_window_top_upper_half;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);

	sequence s_top_write;
		i_cfg_wr && i_cfg_addr == `BCR_OFF_IO_UPPER && be2 && be3;
	endsequence

	sequence s_cap_read;
		i_cfg_rd && i_cfg_addr == `BCR_OFF_CAP_PTR;
	endsequence

	AST_TOP_WRITE: assert property (s_top_write |=> o_io_window_top_upper_half ==
		$past(i_cfg_wdata[31:16])) else $error("window top not written");
	AST_CAP_READ: assert property (s_cap_read |=> o_cfg_rvalid &&
		o_cfg_rdata == 32'h000000dc) else $error("capability pointer wrong");
	// A read may follow the ignored write at once or after one idle cycle
	AST_CAP_RO: assert property (i_cfg_wr && i_cfg_addr == `BCR_OFF_CAP_PTR ##[1:2] s_cap_read
		|=> o_cfg_rdata[31:8] == 24'h0) else $error("capability upper bits not zero");
	AST_INT_PIN: assert property (i_cfg_rd && i_cfg_addr == `BCR_OFF_INT_CTRL
		|=> o_cfg_rdata[15:8] == 8'h00) else $error("interrupt pin not zero");
	AST_PERR_OFF: assert property (!st.perr_resp |=> o_downstream_parity_error_oe_n
		&& !o_data_parity_reported_set) else $error("parity driven while disabled");
	AST_PERR_ON: assert property (st.perr_resp && i_sec_data_parity_err
		|=> !o_downstream_parity_error_oe_n && !o_downstream_parity_error_out_n)
		else $error("parity error not driven");
	AST_APE_SERR: assert property (i_sec_addr_parity_err && st.perr_resp && i_serr_driver_en
		|=> !o_upstream_system_error_oe_n) else $error("address parity not reported");
	AST_SERR_BLOCK: assert property (!st.serr_fwd && !i_sec_addr_parity_err
		|=> o_upstream_system_error_oe_n) else $error("system error forwarded while disabled");
	AST_SERR_FWD: assert property (st.serr_fwd && i_serr_driver_en && st.serr_seen
		|=> !o_upstream_system_error_out_n) else $error("system error not forwarded");
	// Stages two and three first agree three edges after the fall; the flag lands one later
	AST_SERR_PIN: assert property ($fell(i_downstream_system_error_in_n) ##1
		!i_downstream_system_error_in_n [*3] |=> st.serr_seen) else $error("pin not seen");
	AST_FWD_DOWN: assert property (i_pri_io_valid && pri_in && !st.isa_en
		|=> o_fwd_downstream) else $error("window access not forwarded");
	AST_ISA_DOWN: assert property (i_pri_io_valid && st.isa_en && pri_alias
		|=> !o_fwd_downstream) else $error("ISA alias forwarded downstream");
	AST_ISA_UP: assert property (i_sec_io_valid && sec_in && st.isa_en && sec_alias
		|=> o_fwd_upstream) else $error("ISA alias not forwarded upstream");

endmodule : bcr_regs

// *** bcr_far_side.sv ***
// Purpose: Far-side agents: secondary error pin and primary error wire
// Assumes: Both error lines are open drain with pull-ups
// Notes:   Pin level is registered so it only moves on a rising clock edge
`timescale 1ns/10ps
module bcr_far_side (
	input  wire logic i_mclk,
	input  wire logic i_pull_serr,
	input  wire logic i_serr_out_n,
	input  wire logic i_serr_oe_n,
	output logic      o_sec_serr_n,
	output logic      o_pri_serr_line
);
	logic sec_q = 1'h1;
	// Secondary agent pulls its pin low on request, pull-up otherwise
	always @(posedge i_mclk) begin
		sec_q <= ~i_pull_serr;
	end
	assign o_sec_serr_n = sec_q;
	// Pull-up wins whenever the bridge lets go of the wire
	assign o_pri_serr_line = i_serr_oe_n ? 1'h1 : i_serr_out_n;
endmodule : bcr_far_side

// *** tb_bridge_config_header_regs.sv ***
// Purpose: Self-checking bench for the bridge header register block
// Assumes: I/O window 0x1000..0x2fff set through the low base/limit bits
// Notes:   Inputs change on the falling edge; outputs checked there too
`timescale 1ns/10ps
`include "bcr_consts.svh"
module tb_bridge_config_header_regs;
	logic        clk = 1'h0, nrst = 1'h0, wr = 1'h0, rd = 1'h0, pv = 1'h0, sv = 1'h0;
	logic        drv = 1'h0, dpc = 1'h0, dpe = 1'h0, ape = 1'h0, pull = 1'h0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wd = 32'h0, pa = 32'h0, rdat;
	logic [3:0]  be_n = 4'hf, blo = 4'h1, llo = 4'h2;
	logic        rv, pe_n, pe_oe_n, dps, se_n, se_oe_n, fd, fu, isa, ssn, line;
	logic [15:0] top;
	int          n_mismatch = 0, check_count = 0;
	// Rows: ISA bit, address, expected downstream, expected upstream
	localparam logic [34:0] ROWS [8] = '{
		{1'h0, 32'h00001000, 1'h1, 1'h0}, {1'h0, 32'h00002fff, 1'h1, 1'h0},
		{1'h0, 32'h00003000, 1'h0, 1'h1}, {1'h0, 32'h00000fff, 1'h0, 1'h1},
		{1'h1, 32'h00001100, 1'h0, 1'h1}, {1'h1, 32'h000010ff, 1'h1, 1'h0},
		{1'h1, 32'h00002300, 1'h0, 1'h1}, {1'h0, 32'h00002300, 1'h1, 1'h0}};
	// Parity pin, enable, reported bit, primary wire: response off, on without, on with condition
	localparam logic [3:0]  PEXP [3] = '{4'hd, 4'h0, 4'h2};

	bcr_regs dut_u (.i_mclk(clk), .i_nrst(nrst), .i_cfg_wr(wr), .i_cfg_rd(rd),
		.i_cfg_addr(addr), .i_cfg_wdata(wd), .i_upstream_command_byte_enables_n(be_n),
		.i_io_base_low(blo), .i_io_limit_low(llo), .i_serr_driver_en(drv),
		.i_dpr_condition(dpc), .i_sec_data_parity_err(dpe), .i_sec_addr_parity_err(ape),
		.i_downstream_system_error_in_n(ssn), .i_pri_io_valid(pv), .i_pri_io_addr(pa),
		.i_sec_io_valid(sv), .i_sec_io_addr(pa), .o_cfg_rdata(rdat), .o_cfg_rvalid(rv),
		.o_downstream_parity_error_out_n(pe_n), .o_downstream_parity_error_oe_n(pe_oe_n),
		.o_data_parity_reported_set(dps), .o_upstream_system_error_out_n(se_n),
		.o_upstream_system_error_oe_n(se_oe_n), .o_fwd_downstream(fd),
		.o_fwd_upstream(fu), .o_isa_en(isa), .o_io_window_top_upper_half(top));
	bcr_far_side far_u (.i_mclk(clk), .i_pull_serr(pull), .i_serr_out_n(se_n),
		.i_serr_oe_n(se_oe_n), .o_sec_serr_n(ssn), .o_pri_serr_line(line));

	// Free-running clock, 8 ns period
	initial begin
		forever #4 clk = ~clk;
	end
	// Watchdog in case a task hangs beyond every bounded wait
	initial begin
		#400000;
		n_mismatch++;
		close_out();
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One config access; a read is answered one cycle after it is taken
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] b, input logic [31:0] exp);
		@(negedge clk);
		wr = w;
		rd = ~w;
		addr = a;
		wd = d;
		be_n = b;
		@(negedge clk);
		wr = 1'h0;
		rd = 1'h0;
		if (!w) begin
			chk({31'h0, rv}, 32'h1);
			chk(rdat, exp);
		end
	endtask : acc
	// Primary and secondary decode of the same address, pulse one cycle later
	task io(input logic [31:0] a, input logic d, input logic u);
		@(negedge clk);
		pa = a;
		pv = 1'h1;
		sv = 1'h1;
		@(negedge clk);
		pv = 1'h0;
		sv = 1'h0;
		chk({31'h0, fd}, {31'h0, d});
		chk({31'h0, fu}, {31'h0, u});
	endtask : io
	// Pin input passes a sync chain, so allow a bounded settle time
	task wline(input logic v);
		for (int k = 0; k < 12 && line !== v; k++) @(negedge clk);
		chk({31'h0, line}, {31'h0, v});
	endtask : wline
	task close_out;
		$display("Counts: %0d checks, %0d mismatches", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out

	// Main sequence
	initial begin
		repeat (20) @(negedge clk);
		chk({rv, pe_n, pe_oe_n, dps, se_oe_n, fd, fu, isa, top}, 32'h680000);
		nrst = 1'h1;
		acc(1'h0, `BCR_OFF_IO_UPPER, 32'h0, 4'h0, 32'h0);
		$display("Test reset done");
		// Window is set up before any decode is trusted
		acc(1'h1, `BCR_OFF_IO_UPPER, 32'h0, 4'h0, 32'h0);
		foreach (ROWS[i]) begin
			acc(1'h1, `BCR_OFF_INT_CTRL, {13'h0, ROWS[i][34], 18'h0}, 4'hb, 32'h0);
			chk({31'h0, isa}, {31'h0, ROWS[i][34]});
			io(ROWS[i][33:2], ROWS[i][1], ROWS[i][0]);
		end
		$display("Test decode rows done");
		acc(1'h1, `BCR_OFF_IO_UPPER, 32'habcd1234, 4'h3, 32'h0);
		acc(1'h0, `BCR_OFF_IO_UPPER, 32'h0, 4'h0, 32'habcd0000);
		chk({16'h0, top}, 32'habcd);
		acc(1'h1, `BCR_OFF_IO_UPPER, 32'h11110005, 4'hc, 32'h0);
		acc(1'h0, `BCR_OFF_IO_UPPER, 32'h0, 4'h0, 32'habcd0005);
		acc(1'h1, `BCR_OFF_CAP_PTR, 32'hffffffff, 4'h0, 32'h0);
		acc(1'h0, `BCR_OFF_CAP_PTR, 32'h0, 4'h0, 32'hdc);
		acc(1'h1, `BCR_OFF_INT_CTRL, 32'hffffffff, 4'h0, 32'h0);
		acc(1'h0, `BCR_OFF_INT_CTRL, 32'h0, 4'h0, 32'h00070000);
		acc(1'h0, 8'h38, 32'h0, 4'h0, 32'h0);
		$display("Test registers done");
		// Parity response off, then on without and with the reporting condition
		for (int r = 0; r < 3; r++) begin
			acc(1'h1, `BCR_OFF_INT_CTRL, {15'h0, r != 0, 16'h0}, 4'hb, 32'h0);
			@(negedge clk);
			dpe = 1'h1;
			ape = 1'h1;
			dpc = (r != 1);
			drv = 1'h1;
			@(negedge clk);
			dpe = 1'h0;
			ape = 1'h0;
			chk({pe_n, pe_oe_n, dps, line}, PEXP[r]);
		end
		$display("Test parity done");
		// Forwarding off: a held pin must never reach the primary wire
		acc(1'h1, `BCR_OFF_INT_CTRL, 32'h0, 4'hb, 32'h0);
		pull = 1'h1;
		repeat (10) @(negedge clk);
		chk({31'h0, line}, 32'h1);
		acc(1'h1, `BCR_OFF_INT_CTRL, 32'h00020000, 4'hb, 32'h0);
		wline(1'h0);
		pull = 1'h0;
		wline(1'h1);
		$display("Test system error done");
		// Second reset in mid-run clears the window again
		nrst = 1'h0;
		repeat (5) @(negedge clk);
		chk({rv, pe_n, pe_oe_n, dps, se_oe_n, fd, fu, isa, top}, 32'h680000);
		nrst = 1'h1;
		acc(1'h0, `BCR_OFF_IO_UPPER, 32'h0, 4'h0, 32'h0);
		$display("Test second reset done");
		close_out();
	end
endmodule : tb_bridge_config_header_regs
